// ===== hw/bus_cycle_defs.vh
`ifndef BUS_CYCLE_DEFS_VH
`define BUS_CYCLE_DEFS_VH

// =====================================================
// Register map (byte addresses, APB word registers)
`define REG_CONFIG 12'h000
`define REG_COMMAND 12'h004
`define REG_STATUS 12'h008
`define REG_READ_DATA 12'h00c

// =====================================================
// Configuration fields
`define CFG_CMD_WAIT_LSB 0
`define CFG_CMD_WAIT_MSB 3
`define CFG_TRISTATE_BIT 4
`define CFG_MUX_BIT 5
`define CFG_ASYNC_READY_BIT 6
`define CFG_READY_EN_BIT 7
`define CFG_ALE_LONG_BIT 8
`define CFG_RESET 32'h00000000

// Command fields: write starts a cycle
`define CMD_ADDR_LSB 0
`define CMD_ADDR_MSB 15
`define CMD_DATA_LSB 16
`define CMD_DATA_MSB 31

// Status fields
`define ST_BUSY_BIT 0
`define ST_HOLD_BIT 1
`define ST_WAITS_LSB 8
`define ST_WAITS_MSB 15

// =====================================================
// Timing
`define HALF_CLOCK_CYCLES 4
`define RELEASE_CS_HALF_CLOCKS 1

`endif

// ===== hw/external_bus_wait_and_release.v
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "bus_cycle_defs.vh"

module external_bus_wait_and_release (
  input wire clock,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ready_n,
  input wire hold_n,
  input wire [15:0] data_in,
  output reg reference_clock_output,
  output reg [15:0] address_out,
  output reg [15:0] data_out,
  output reg data_oe_n,
  output reg address_oe_n,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg strobe_oe_n,
  output reg ale,
  output reg chip_select_n,
  output reg chip_select_oe_n,
  output reg hold_ack_n,
  output reg bus_request_output_n
);
  localparam ST_IDLE = 4'h0;
  localparam ST_ADDR = 4'h1;
  localparam ST_CMD = 4'h2;
  localparam ST_READY = 4'h3;
  localparam ST_END = 4'h4;
  localparam ST_MUX = 4'h5;
  localparam ST_TRI = 4'h6;
  localparam ST_CS_HIGH = 4'h7;
  localparam ST_HELD = 4'h8;

  // =====================================================
  // Half clock timebase
  wire half_tick;
  wire rising_tick;
  wire ref_clk;

  half_clock_gen #(
    .DIVIDE(`HALF_CLOCK_CYCLES)
  ) timebase (
    .clock(clock),
    .reset(reset),
    .half_tick(half_tick),
    .rising_tick(rising_tick),
    .reference_clock_output(ref_clk)
  );

  // =====================================================
  // Pin synchronisers
  reg ready_meta;
  reg ready_sync;
  reg ready_async;
  reg hold_meta;
  reg hold_sync;
  reg [15:0] data_meta;
  reg [15:0] data_sync;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ready_meta <= 1'b1;
      ready_sync <= 1'b1;
      ready_async <= 1'b1;
      hold_meta <= 1'b1;
      hold_sync <= 1'b1;
      data_meta <= 16'h0000;
      data_sync <= 16'h0000;
    end else begin
      // Bus data stands for the whole strobe, so two stages cost no cycle
      data_meta <= data_in;
      data_sync <= data_meta;
      ready_meta <= ready_n;
      ready_sync <= ready_meta;
      hold_meta <= hold_n;
      hold_sync <= hold_meta;
      // Extra stage, latched once per reference clock rising edge
      if (rising_tick) begin
        ready_async <= ready_sync;
      end
    end
  end

  // =====================================================
  // Registers
  reg [31:0] config_reg;
  reg [15:0] cmd_addr;
  reg [15:0] cmd_data;
  reg cmd_write;
  reg cmd_pending;
  reg [15:0] read_data;
  reg [7:0] wait_count;

  wire [3:0] cmd_waits = config_reg[`CFG_CMD_WAIT_MSB:`CFG_CMD_WAIT_LSB];
  wire tri_en = config_reg[`CFG_TRISTATE_BIT];
  wire mux_en = config_reg[`CFG_MUX_BIT];
  wire async_en = config_reg[`CFG_ASYNC_READY_BIT];
  wire ready_en = config_reg[`CFG_READY_EN_BIT];
  wire ale_long = config_reg[`CFG_ALE_LONG_BIT];

  reg [3:0] state;
  reg [4:0] half_count;
  reg held;

  wire busy = (state != ST_IDLE) || cmd_pending;
  wire ready_now = async_en ? ready_async : ready_sync;
  wire access = psel && penable;

  function is_addr;
    input [11:0] a;
    input [11:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // =====================================================
  // APB slave, access phase with one wait state
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      config_reg <= `CFG_RESET;
      cmd_addr <= 16'h0000;
      cmd_data <= 16'h0000;
      cmd_write <= 1'b0;
      cmd_pending <= 1'b0;
    end else begin
      // Ready follows the first access edge, so every transfer has one wait state
      pready <= access && !pready;
      pslverr <= 1'b0;
      if (state == ST_ADDR) begin
        cmd_pending <= 1'b0;
      end
      if (access && !pready) begin
        if (pwrite) begin
          if (is_addr(paddr, `REG_CONFIG)) begin
            config_reg <= {23'h000000, pwdata[8:0]};
          end else if (is_addr(paddr, `REG_COMMAND)) begin
            // Command while busy is refused; no queueing
            if (busy || held) begin
              pslverr <= 1'b1;
            end else begin
              cmd_addr <= pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
              cmd_data <= pwdata[`CMD_DATA_MSB:`CMD_DATA_LSB];
              cmd_write <= 1'b1;
              cmd_pending <= 1'b1;
            end
          end else if (is_addr(paddr, `REG_READ_DATA)) begin
            // Writing here launches a read cycle at the given address
            if (busy || held) begin
              pslverr <= 1'b1;
            end else begin
              cmd_addr <= pwdata[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
              cmd_write <= 1'b0;
              cmd_pending <= 1'b1;
            end
          end else if (!is_addr(paddr, `REG_STATUS)) begin
            pslverr <= 1'b1;
          end
        end else begin
          if (is_addr(paddr, `REG_CONFIG)) begin
            prdata <= config_reg;
          end else if (is_addr(paddr, `REG_STATUS)) begin
            prdata <= {16'h0000, wait_count, 6'h00, held, busy};
          end else if (is_addr(paddr, `REG_READ_DATA)) begin
            prdata <= {16'h0000, read_data};
          end else if (is_addr(paddr, `REG_COMMAND)) begin
            prdata <= {cmd_data, cmd_addr};
          end else begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        end
      end
    end
  end

  // =====================================================
  // Bus cycle sequencer, advances on half clock ticks
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      half_count <= 5'h00;
      held <= 1'b0;
      wait_count <= 8'h00;
      read_data <= 16'h0000;
      reference_clock_output <= 1'b0;
      address_out <= 16'h0000;
      data_out <= 16'h0000;
      data_oe_n <= 1'b1;
      address_oe_n <= 1'b0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      strobe_oe_n <= 1'b0;
      ale <= 1'b0;
      chip_select_n <= 1'b1;
      chip_select_oe_n <= 1'b0;
      hold_ack_n <= 1'b1;
      bus_request_output_n <= 1'b1;
    end else begin
      reference_clock_output <= ref_clk;
      if (half_tick) begin
        case (state)
          ST_IDLE: begin
            // An accepted command runs first; a hold alone must not strand it
            if (cmd_pending) begin
              address_out <= cmd_addr;
              data_out <= cmd_data;
              chip_select_n <= 1'b0;
              ale <= 1'b1;
              wait_count <= 8'h00;
              half_count <= ale_long ? 5'h03 : 5'h01;
              state <= ST_ADDR;
            end else if (!hold_sync) begin
              chip_select_n <= 1'b1;
              half_count <= 5'h00;
              state <= ST_CS_HIGH;
            end
          end
          ST_ADDR: begin
            if (half_count == 5'h00) begin
              ale <= 1'b0;
              if (cmd_write) begin
                write_strobe_n <= 1'b0;
                data_oe_n <= 1'b0;
              end else begin
                read_strobe_n <= 1'b0;
                data_oe_n <= 1'b1;
              end
              // Programmed command waits, two half clocks each
              half_count <= {cmd_waits, 1'b1};
              state <= ST_CMD;
            end else begin
              half_count <= half_count - 5'h01;
            end
          end
          ST_CMD: begin
            if (half_count == 5'h00) begin
              state <= ready_en ? ST_READY : ST_END;
            end else begin
              half_count <= half_count - 5'h01;
            end
          end
          ST_READY: begin
            // Sample point: reference clock rising edge
            if (rising_tick) begin
              // The extra stage alone cannot promise a wait when ready came early
              if (ready_now || (async_en && wait_count == 8'h00)) begin
                wait_count <= wait_count + 8'h01;
              end else begin
                state <= ST_END;
              end
            end
          end
          ST_END: begin
            if (!cmd_write) begin
              read_data <= data_sync;
            end
            // Partner releases ready on this rising strobe edge
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            data_oe_n <= 1'b1;
            chip_select_n <= 1'b1;
            half_count <= 5'h01;
            if (mux_en) begin
              state <= ST_MUX;
            end else if (tri_en) begin
              state <= ST_TRI;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_MUX: begin
            if (half_count == 5'h00) begin
              half_count <= 5'h01;
              state <= tri_en ? ST_TRI : ST_IDLE;
            end else begin
              half_count <= half_count - 5'h01;
            end
          end
          ST_TRI: begin
            // Gap lets the partner deassert ready before the next sample
            if (half_count == 5'h00) begin
              state <= ST_IDLE;
            end else begin
              half_count <= half_count - 5'h01;
            end
          end
          ST_CS_HIGH: begin
            if (half_count == `RELEASE_CS_HALF_CLOCKS - 1) begin
              chip_select_oe_n <= 1'b1;
              address_oe_n <= 1'b1;
              strobe_oe_n <= 1'b1;
              data_oe_n <= 1'b1;
              hold_ack_n <= 1'b0;
              held <= 1'b1;
              state <= ST_HELD;
            end else begin
              half_count <= half_count + 5'h01;
            end
          end
          ST_HELD: begin
            bus_request_output_n <= !cmd_pending;
            if (hold_sync) begin
              hold_ack_n <= 1'b1;
              address_oe_n <= 1'b0;
              strobe_oe_n <= 1'b0;
              chip_select_oe_n <= 1'b0;
              bus_request_output_n <= 1'b1;
              held <= 1'b0;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ===== hw/half_clock_gen.v
`timescale 1ns/100ps
`include "bus_cycle_defs.vh"

// =====================================================
// Half clock period tick generator
module half_clock_gen #(
  parameter DIVIDE = `HALF_CLOCK_CYCLES
) (
  input wire clock,
  input wire reset,
  output reg half_tick,
  output reg rising_tick,
  output reg reference_clock_output
);
  reg [7:0] count;

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 8'h00;
      half_tick <= 1'b0;
      rising_tick <= 1'b0;
      reference_clock_output <= 1'b0;
    end else begin
      half_tick <= 1'b0;
      rising_tick <= 1'b0;
      if (count == DIVIDE - 1) begin
        count <= 8'h00;
        // Both edges of the derived clock launch work
        half_tick <= 1'b1;
        rising_tick <= ~reference_clock_output;
        reference_clock_output <= ~reference_clock_output;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
endmodule

// ===== verif/bus_partner_model.sv
`timescale 1ns/100ps
// ==========
// Memory that stretches each cycle by a set number of reference periods
module bus_partner_model (
  input wire ref_clk,
  input wire rd_n,
  input wire wr_n,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  input wire [3:0] waits,
  output logic ready_n,
  output logic [15:0] rdata
);
  logic [15:0] mem [16];
  logic [3:0] cnt = 4'h0;
  initial ready_n = 1'b1;
  initial rdata = 16'h0000;
  // Output delay after the falling edge keeps ready settled at the rising sample
  always @(negedge ref_clk) begin
    #1;
    if (!rd_n || !wr_n) begin
      if (cnt >= waits) ready_n <= 1'b0;
      else cnt <= cnt + 4'h1;
    end
  end
  // Re-armed at the trailing strobe edge, well before the next sample
  always @(posedge rd_n or posedge wr_n) begin
    ready_n <= 1'b1;
    cnt <= 4'h0;
    rdata <= ~rdata;
  end
  always @(posedge wr_n) mem[addr[3:0]] <= wdata;
  always @(negedge rd_n) rdata <= mem[addr[3:0]];
endmodule

// ===== verif/ext_bus_properties.sv
`timescale 1ns/100ps
// ==========
// Port checks of the bus cycle controller
module ext_bus_properties (
  input wire clock,
  input wire reset,
  input wire hold_n,
  input wire reference_clock_output,
  input wire [15:0] address_out,
  input wire data_oe_n,
  input wire address_oe_n,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire strobe_oe_n,
  input wire chip_select_n,
  input wire chip_select_oe_n,
  input wire hold_ack_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  AST_HALF: assert property ($rose(reference_clock_output) |=>
    $stable(reference_clock_output)[*3] ##1 !reference_clock_output) else $error("half");
  AST_CMD_LEN: assert property ($fell(write_strobe_n) |=> !write_strobe_n[*7])
    else $error("strobe short");
  AST_ADDR_HOLD: assert property (!write_strobe_n && $past(!write_strobe_n) |->
    $stable(address_out)) else $error("addr moved");
  AST_ONE_STROBE: assert property (read_strobe_n || write_strobe_n)
    else $error("two strobes");
  AST_GRANT_IDLE: assert property ($fell(hold_ack_n) |->
    read_strobe_n && write_strobe_n && $past(read_strobe_n)) else $error("grant busy");
  AST_FLOAT: assert property (!hold_ack_n |-> address_oe_n && data_oe_n && strobe_oe_n)
    else $error("not floated");
  AST_CS_OFF: assert property ($rose(chip_select_oe_n) |-> chip_select_n &&
    $past(chip_select_n, 4) && !$past(chip_select_oe_n, 4)) else $error("cs release");
  AST_RESUME: assert property ($rose(hold_n) && !hold_ack_n |-> ##[1:16] hold_ack_n)
    else $error("no resume");
  AST_STAY: assert property (!hold_ack_n && !hold_n |=> !hold_ack_n)
    else $error("grant lost");
  cover property ($fell(hold_ack_n));
  cover property ($fell(read_strobe_n));
  cover property ($fell(write_strobe_n));
endmodule

bind external_bus_wait_and_release ext_bus_properties i_props (.clock(clock), .reset(reset),
  .hold_n(hold_n), .reference_clock_output(reference_clock_output),
  .address_out(address_out), .data_oe_n(data_oe_n), .address_oe_n(address_oe_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .strobe_oe_n(strobe_oe_n), .chip_select_n(chip_select_n),
  .chip_select_oe_n(chip_select_oe_n), .hold_ack_n(hold_ack_n));

// ===== verif/tb_top.sv
`timescale 1ns/100ps
`include "bus_cycle_defs.vh"
// ==========
// Bench
module tb_top;
  logic clock, reset, psel, penable, pwrite, hold_n, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [3:0] waits;
  logic [7:0] wc [4];
  wire [31:0] prdata;
  wire [15:0] din, aout, dout;
  wire pready, rdy_n, rclk, d_oe, a_oe, rd_n, wr_n, s_oe, cs_oe, ack_n, e_w;
  int mismatches, num_checks, lowc, t, n;
  int lc [4];
  logic [3:0] wt [4] = '{4'h0, 4'h2, 4'h4, 4'h0};
  external_bus_wait_and_release i_dut (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(e_w), .ready_n(rdy_n), .hold_n(hold_n), .data_in(din),
    .reference_clock_output(rclk), .address_out(aout), .data_out(dout),
    .data_oe_n(d_oe), .address_oe_n(a_oe), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .strobe_oe_n(s_oe), .ale(), .chip_select_n(), .chip_select_oe_n(cs_oe),
    .hold_ack_n(ack_n), .bus_request_output_n());
  bus_partner_model i_mem (.ref_clk(rclk), .rd_n(rd_n), .wr_n(wr_n), .addr(aout),
    .wdata(dout), .waits(waits), .ready_n(rdy_n), .rdata(din));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) if (wr_n === 1'b0) lowc++;
  task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
    if (pready !== 1'b1) mismatches++;
    q = prdata;
    e = e_w;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cyc(input logic [31:0] c, input logic [3:0] w, input logic [11:0] a,
    input logic [31:0] d, input logic h);
    waits <= w;
    apb(1'b1, `REG_CONFIG, c);
    lowc = 0;
    // Start on a fixed reference phase so that cycle lengths repeat
    @(posedge rclk);
    apb(1'b1, a, d);
    if (h) hold_n <= 1'b0;
    t = 0;
    do begin
      apb(1'b0, `REG_STATUS, 32'h0);
      t++;
    end while (q[`ST_BUSY_BIT] !== 1'b0 && q[`ST_HOLD_BIT] !== 1'b1 && t < 100);
    if (t >= 100) mismatches++;
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    hold_n = 1'b1;
    waits = 4'h0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    apb(1'b0, `REG_CONFIG, 32'h0);
    chk("cfg", q, `CFG_RESET);
    apb(1'b0, 12'h0f0, 32'h0);
    chk("unmapped", e, 1'b1);
    cyc(32'h02, 4'h0, `REG_COMMAND, 32'hbeef0005, 1'b0);
    // Two command waits of two half clocks each, plus three base half clocks
    chk("strobe", lowc, (2 * 2 + 3) * `HALF_CLOCK_CYCLES);
    cyc(32'hb0, 4'h1, `REG_READ_DATA, 32'h5, 1'b0);
    apb(1'b0, `REG_READ_DATA, 32'h0);
    chk("rdata", q[15:0], 16'hbeef);
    for (int i = 0; i < 4; i++) begin
      cyc(i == 3 ? 32'hc0 : 32'h80, wt[i], `REG_COMMAND, 32'h12340006, 1'b0);
      wc[i] = q[`ST_WAITS_MSB:`ST_WAITS_LSB];
      lc[i] = lowc;
    end
    chk("sync", wc[0], 8'h00);
    chk("async", wc[3] > wc[0], 1'b1);
    chk("waits", wc[2] - wc[1], 8'h02);
    chk("stretch", lc[2] - lc[1], 4 * `HALF_CLOCK_CYCLES);
    // Hold arrives mid-cycle: the cycle must still run to its end
    cyc(32'h80, 4'h4, `REG_COMMAND, 32'h55550007, 1'b1);
    chk("held", q[`ST_WAITS_MSB:`ST_WAITS_LSB], wc[2]);
    n = 0;
    while (ack_n !== 1'b0 && n++ < 99) @(negedge clock);
    chk("float", {a_oe, d_oe, s_oe, cs_oe, ack_n}, 5'h1e);
    @(posedge clock);
    apb(1'b1, `REG_COMMAND, 32'h0);
    chk("refuse", e, 1'b1);
    hold_n <= 1'b1;
    n = 0;
    while (ack_n !== 1'b1 && n++ < 99) @(negedge clock);
    chk("resume", {a_oe, ack_n}, 2'h1);
    tally_and_finish;
  end
  initial begin
    repeat (30000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
endmodule
